// *** core/rss_seq.sv ***
// Purpose: reset sequencer, low supply and auxiliary supply logic
// Assumes: analog comparators outside, hysteresis inside comparators
// Notes: reset pin is open drain; oe low means drive low
`timescale 1ns/100ps
`default_nettype none
`include "rss_cfg.svh"
module rss_seq (
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic            rst_pin_in,
    output logic                 rst_pin_out,
    output logic                 rst_pin_oe_n,
    input  wire logic            pin_low_latch,
    output logic                 pin_latch_clr,
    input  wire logic            low_supply_cmp,
    input  wire logic            aux_supply_cmp,
    input  wire logic            watchdog_underflow,
    input  wire logic            opt_long_delay,
    input  wire logic            opt_low_supply_en,
    input  wire rss_pkg::rss_lvl_t opt_threshold_sel,
    output rss_pkg::rss_lvl_t    threshold_sel,
    output logic                 aux_supply_flag,
    input  wire logic            aux_irq_enable_wr,
    input  wire logic            aux_irq_enable_val,
    output logic                 aux_supply_irq_enable,
    input  wire logic            irq_ack,
    output logic                 aux_irq_req,
    input  wire logic            cause_wr,
    input  wire logic            low_cause_wdata,
    input  wire logic            wdg_cause_wdata,
    output logic                 low_supply_reset_cause,
    output logic                 watchdog_reset_cause,
    output logic                 cpu_reset,
    output logic                 vector_fetch,
    output logic [15:0]          vector_addr
);
    import rss_pkg::*;

    // reset image of the status byte, held as a constant so single bits can be picked
    localparam logic [7:0] SIC_RST = `RSS_SIC_RST;

    // ************************************************
    // input synchronisation
    // ************************************************
    logic pin_low_s;
    logic latch_s;
    logic low_s;
    logic aux_s;
    rss_sync #(.RST_VAL(1'b1)) u_pin (.clk(clk), .rst(rst), .d(~rst_pin_in), .q(pin_low_s));
    rss_sync #(.RST_VAL(1'b0)) u_lat (.clk(clk), .rst(rst), .d(pin_low_latch), .q(latch_s));
    rss_sync #(.RST_VAL(1'b1)) u_low (.clk(clk), .rst(rst), .d(low_supply_cmp), .q(low_s));
    rss_sync #(.RST_VAL(1'b0)) u_aux (.clk(clk), .rst(rst), .d(aux_supply_cmp), .q(aux_s));

    // ************************************************
    // reset sources
    // ************************************************
    logic low_act;
    logic wdg_act;
    logic ext_act;
    logic [7:0] wdg_cnt_ff;
    logic       drive_low;
    logic [2:0] drv_hist_ff;
    logic       own_drive;
    assign threshold_sel = opt_threshold_sel;
    assign low_act = opt_low_supply_en & low_s;

    // the pin reads back our own pull-down; ignore it while we drive and
    // for as long as the synchroniser still shows the released level as low
    always_ff @(posedge clk) begin
        if (rst) begin
            drv_hist_ff <= 3'b111;
        end else begin
            drv_hist_ff <= {drv_hist_ff[1:0], drive_low};
        end
    end
    assign own_drive = drive_low | (|drv_hist_ff);
    assign ext_act = (latch_s | pin_low_s) & ~own_drive;
    assign pin_latch_clr = latch_s | own_drive;

    always_ff @(posedge clk) begin
        if (rst) begin
            wdg_cnt_ff <= 8'h00;
        end else if (watchdog_underflow) begin
            wdg_cnt_ff <= 8'(`RSS_WDG_OUT_CYC);
        end else if (wdg_cnt_ff != 8'h00) begin
            wdg_cnt_ff <= wdg_cnt_ff - 8'h01;
        end
    end
    assign wdg_act = watchdog_underflow | (wdg_cnt_ff != 8'h00);
    logic any_src;
    assign any_src = low_act | wdg_act | ext_act;

    // ************************************************
    // sequencer
    // ************************************************
    rss_state_t state_ff;
    rss_state_t nxt_state;
    logic [12:0] dly_cnt_ff;
    logic [1:0]  fetch_cnt_ff;
    logic [12:0] dly_len;
    assign dly_len = opt_long_delay ? `RSS_DLY_LONG : `RSS_DLY_SHORT;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            RSS_IDLE:  if (any_src) nxt_state = RSS_ACT;
            RSS_ACT:   if (!any_src) nxt_state = RSS_DLY;
            RSS_DLY: begin
                if (any_src) begin
                    nxt_state = RSS_ACT;
                end else if (dly_cnt_ff == dly_len - 13'd1) begin
                    nxt_state = RSS_FETCH;
                end
            end
            RSS_FETCH: begin
                if (any_src) begin
                    nxt_state = RSS_ACT;
                end else if (fetch_cnt_ff == `RSS_FETCH_CYC - 2'd1) begin
                    nxt_state = RSS_IDLE;
                end
            end
            default:   nxt_state = RSS_ACT;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= RSS_ACT;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || state_ff != RSS_DLY || any_src) begin
            dly_cnt_ff <= 13'd0;
        end else begin
            dly_cnt_ff <= dly_cnt_ff + 13'd1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || state_ff != RSS_FETCH) begin
            fetch_cnt_ff <= 2'd0;
        end else begin
            fetch_cnt_ff <= fetch_cnt_ff + 2'd1;
        end
    end

    // ************************************************
    // pin and cpu outputs
    // ************************************************
    // the pin is also held low through the active phase so it never glitches high
    assign drive_low = (state_ff == RSS_ACT) | (state_ff == RSS_DLY)
                       | low_act | wdg_act;
    assign rst_pin_out = 1'b0;
    assign rst_pin_oe_n = ~drive_low;
    assign cpu_reset = (state_ff != RSS_IDLE);
    assign vector_fetch = (state_ff == RSS_FETCH);
    assign vector_addr = `RSS_VEC_ADDR + {15'd0, fetch_cnt_ff[0]};

    // ************************************************
    // reset cause flags
    // ************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            low_supply_reset_cause <= SIC_RST[`RSS_BIT_LOW_CAUSE];
        end else if (low_act) begin
            low_supply_reset_cause <= 1'b1;
        end else if (cause_wr && !low_cause_wdata) begin
            low_supply_reset_cause <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            watchdog_reset_cause <= SIC_RST[`RSS_BIT_WDG_CAUSE];
        end else if (low_act) begin
            watchdog_reset_cause <= 1'b0;
        end else if (wdg_act) begin
            watchdog_reset_cause <= 1'b1;
        end else if (cause_wr && !wdg_cause_wdata) begin
            watchdog_reset_cause <= 1'b0;
        end
    end

    // ************************************************
    // auxiliary supply detector
    // ************************************************
    logic aux_prev_ff;
    logic ie_rise;
    assign aux_supply_flag = opt_low_supply_en & aux_s;

    always_ff @(posedge clk) begin
        if (rst) begin
            aux_supply_irq_enable <= SIC_RST[`RSS_BIT_AUX_IE];
        end else if (cpu_reset) begin
            aux_supply_irq_enable <= 1'b0;
        end else if (aux_irq_enable_wr) begin
            aux_supply_irq_enable <= aux_irq_enable_val;
        end
    end

    // during reset the tracked flag follows silently so a fast rise is not reported
    always_ff @(posedge clk) begin
        if (rst) begin
            aux_prev_ff <= 1'b0;
        end else begin
            aux_prev_ff <= aux_supply_flag;
        end
    end

    assign ie_rise = aux_irq_enable_wr & aux_irq_enable_val & ~aux_supply_irq_enable
                     & aux_supply_flag & ~cpu_reset;

    always_ff @(posedge clk) begin
        if (rst || cpu_reset || !opt_low_supply_en) begin
            aux_irq_req <= 1'b0;
        end else if ((aux_supply_irq_enable && aux_supply_flag != aux_prev_ff) || ie_rise) begin
            aux_irq_req <= 1'b1;
        end else if (irq_ack) begin
            aux_irq_req <= 1'b0;
        end
    end

    // ************************************************
    // assertions
    // ************************************************
    a_delay_pin_low: assert property (@(posedge clk) disable iff (rst)
        state_ff == RSS_DLY |-> !rst_pin_oe_n)
        else $error("pin released during delay");
    a_fetch_two_cyc: assert property (@(posedge clk) disable iff (rst)
        $rose(vector_fetch) && !any_src ##1 !any_src |=> !vector_fetch)
        else $error("fetch length wrong");
    a_fetch_addr: assert property (@(posedge clk) disable iff (rst)
        $rose(vector_fetch) |-> vector_addr == 16'hfffe)
        else $error("wrong vector");
    a_order_phase: assert property (@(posedge clk) disable iff (rst)
        $rose(vector_fetch) |-> $past(state_ff) == RSS_DLY)
        else $error("fetch not after delay");
    a_short_delay: assert property (@(posedge clk) disable iff (rst)
        $rose(state_ff == RSS_DLY) && !opt_long_delay && !any_src
        ##1 (!any_src && !opt_long_delay) [*8] |-> state_ff == RSS_DLY)
        else $error("delay ended early");
    a_restart_dly: assert property (@(posedge clk) disable iff (rst)
        state_ff == RSS_DLY && any_src |=> dly_cnt_ff == 13'd0)
        else $error("delay not restarted");
    a_wdg_pulse: assert property (@(posedge clk) disable iff (rst)
        watchdog_underflow |=> !rst_pin_oe_n && watchdog_reset_cause || low_act)
        else $error("watchdog pulse missing");
    a_low_drive: assert property (@(posedge clk) disable iff (rst)
        low_act |-> !rst_pin_oe_n)
        else $error("low supply not driving pin");
    a_no_low_dis: assert property (@(posedge clk) disable iff (rst)
        !opt_low_supply_en |-> !low_act && !aux_supply_flag && !aux_irq_req)
        else $error("disabled detector active");
    a_aux_toggle: assert property (@(posedge clk) disable iff (rst)
        aux_supply_irq_enable && !cpu_reset && opt_low_supply_en
        && aux_supply_flag != aux_prev_ff |=> aux_irq_req)
        else $error("toggle without request");
    a_low_cause: assert property (@(posedge clk) disable iff (rst)
        low_act |=> low_supply_reset_cause && !watchdog_reset_cause)
        else $error("cause flags wrong");
    a_act_pin_low: assert property (@(posedge clk) disable iff (rst)
        state_ff == RSS_ACT |-> !rst_pin_oe_n)
        else $error("pin released in active phase");
    a_src_enters: assert property (@(posedge clk) disable iff (rst)
        state_ff == RSS_IDLE && any_src |=> state_ff == RSS_ACT)
        else $error("source did not start reset");
    a_long_delay: assert property (@(posedge clk) disable iff (rst)
        $rose(state_ff == RSS_DLY) && opt_long_delay && !any_src
        ##1 (!any_src && opt_long_delay) [*8] |-> state_ff == RSS_DLY)
        else $error("long delay ended early");
    a_fetch_second: assert property (@(posedge clk) disable iff (rst)
        vector_fetch && $past(vector_fetch) |-> vector_addr == 16'hffff)
        else $error("wrong second vector byte");
    a_idle_run: assert property (@(posedge clk) disable iff (rst)
        state_ff == RSS_IDLE |-> !cpu_reset && !vector_fetch)
        else $error("idle while in reset");
    a_wdg_width: assert property (@(posedge clk) disable iff (rst)
        wdg_cnt_ff != 8'h00 |-> !rst_pin_oe_n)
        else $error("watchdog pulse cut short");
    a_req_in_reset: assert property (@(posedge clk) disable iff (rst)
        cpu_reset |=> !aux_irq_req)
        else $error("request during reset");
    a_ack_clears: assert property (@(posedge clk) disable iff (rst)
        aux_irq_req && irq_ack && !ie_rise
        && !(aux_supply_irq_enable && aux_supply_flag != aux_prev_ff) |=> !aux_irq_req)
        else $error("ack did not clear request");
    a_ie_write: assert property (@(posedge clk) disable iff (rst)
        aux_irq_enable_wr && !cpu_reset |=> aux_supply_irq_enable == $past(aux_irq_enable_val))
        else $error("enable write lost");
    a_ie_req: assert property (@(posedge clk) disable iff (rst)
        ie_rise && opt_low_supply_en |=> aux_irq_req)
        else $error("enable with flag set gave no request");
    a_wdg_cause_clr: assert property (@(posedge clk) disable iff (rst)
        cause_wr && !wdg_cause_wdata && !low_act && !wdg_act |=> !watchdog_reset_cause)
        else $error("watchdog cause not cleared");
    a_low_cause_clr: assert property (@(posedge clk) disable iff (rst)
        cause_wr && !low_cause_wdata && !low_act |=> !low_supply_reset_cause)
        else $error("low supply cause not cleared");
    a_low_keeps: assert property (@(posedge clk) disable iff (rst)
        low_supply_reset_cause && !cause_wr |=> low_supply_reset_cause)
        else $error("low supply cause lost");

    c_ext_reset: cover property (@(posedge clk) $rose(ext_act) ##[1:300] $rose(vector_fetch));
    c_wdg_reset: cover property (@(posedge clk) watchdog_underflow ##[1:300] $rose(vector_fetch));
    c_aux_irq:   cover property (@(posedge clk) $rose(aux_irq_req));
    c_restart:   cover property (@(posedge clk) state_ff == RSS_DLY ##1 state_ff == RSS_ACT);
endmodule : rss_seq
`default_nettype wire

// *** core/rss_cfg.svh ***
// Purpose: constants for the reset sequencer and supply monitor
// Assumes: cpu clock of 10 MHz
// Notes: timing counts in cpu cycles, except the watchdog output width, which is given in ns
`ifndef RSS_CFG_SVH
`define RSS_CFG_SVH
`define RSS_CLK_MHZ       10
`define RSS_DLY_SHORT     13'd256
`define RSS_DLY_LONG      13'd4096
`define RSS_FETCH_CYC     2'd2
`define RSS_WDG_OUT_NS    1000
`define RSS_WDG_OUT_CYC   (((`RSS_WDG_OUT_NS * `RSS_CLK_MHZ) + 999) / 1000)
`define RSS_VEC_ADDR      16'hfffe
`define RSS_BIT_WDG_CAUSE 0
`define RSS_BIT_LOW_CAUSE 4
`define RSS_BIT_AUX_FLAG  5
`define RSS_BIT_AUX_IE    6
`define RSS_SIC_RST       8'h00
`endif

// *** core/rss_pkg.sv ***
// Purpose: types for the reset sequencer
// Assumes: nothing
// Notes: one-hot state codes
package rss_pkg;
    typedef enum logic [3:0] {
        RSS_IDLE  = 4'b0001,
        RSS_ACT   = 4'b0010,
        RSS_DLY   = 4'b0100,
        RSS_FETCH = 4'b1000
    } rss_state_t;
    typedef logic [1:0] rss_lvl_t;
endpackage : rss_pkg

// *** core/rss_sync.sv ***
// Purpose: two flip-flop synchroniser
// Assumes: one clock
// Notes: reset value parameter
`timescale 1ns/100ps
`default_nettype none
module rss_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic d,
    output logic      q
);
    logic meta_ff;
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_ff <= RST_VAL;
            q       <= RST_VAL;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule : rss_sync
`default_nettype wire

// *** test/rss_ext_model.sv ***
// Purpose: far side of the reset pin: pull-up, outside pull-down, edge latch
// Assumes: pin is open drain, oe_n low means the device pulls low
// Notes: the latch catches a low edge with no clock running
`timescale 1ns/100ps
`default_nettype none
module rss_ext_model (
    input  wire logic ext_pull_low,
    input  wire logic rst_pin_out,
    input  wire logic rst_pin_oe_n,
    input  wire logic pin_latch_clr,
    output logic      pin_level,
    output logic      pin_low_latch
);
    // ****************************************
    // wired pin with weak pull-up
    // ****************************************
    assign pin_level = (!rst_pin_oe_n && !rst_pin_out) ? 1'b0 :
                       (ext_pull_low ? 1'b0 : 1'b1);
    // ****************************************
    // asynchronous low edge catcher
    // ****************************************
    initial pin_low_latch = 1'b0;
    always @(negedge pin_level or posedge pin_latch_clr) begin
        if (pin_latch_clr)
            pin_low_latch <= 1'b0;
        else
            pin_low_latch <= 1'b1;
    end
endmodule : rss_ext_model
`default_nettype wire

// *** test/testbench.sv ***
// Purpose: self-checking bench for the reset sequencer
// Assumes: inputs change 10 ns after each rising edge, outputs read then
// Notes: delay lengths compared by difference to stay latency neutral
`timescale 1ns/100ps
`default_nettype none
`include "rss_cfg.svh"
module testbench;
    import rss_pkg::*;
    logic clk, rst, pin_level, pin_low_latch, pin_latch_clr, ext_low;
    logic rst_pin_out, rst_pin_oe_n, low_cmp, aux_cmp, wdg, opt_long, opt_en;
    logic ie_wr, ie_val, ie, ack, req, cause_wr, low_wd, wdg_wd, aux_flag;
    logic low_cause, wdg_cause, cpu_reset, vector_fetch;
    logic [15:0] vector_addr;
    rss_lvl_t opt_thr, thr;
    int error_cnt, checks_done, n0, ns, nl, nr;
    rss_ext_model ext (.ext_pull_low(ext_low), .rst_pin_out(rst_pin_out),
        .rst_pin_oe_n(rst_pin_oe_n), .pin_latch_clr(pin_latch_clr),
        .pin_level(pin_level), .pin_low_latch(pin_low_latch));
    rss_seq dut (.clk(clk), .rst(rst), .rst_pin_in(pin_level), .rst_pin_out(rst_pin_out),
        .rst_pin_oe_n(rst_pin_oe_n), .pin_low_latch(pin_low_latch),
        .pin_latch_clr(pin_latch_clr), .low_supply_cmp(low_cmp), .aux_supply_cmp(aux_cmp),
        .watchdog_underflow(wdg), .opt_long_delay(opt_long), .opt_low_supply_en(opt_en),
        .opt_threshold_sel(opt_thr), .threshold_sel(thr), .aux_supply_flag(aux_flag),
        .aux_irq_enable_wr(ie_wr), .aux_irq_enable_val(ie_val),
        .aux_supply_irq_enable(ie), .irq_ack(ack), .aux_irq_req(req),
        .cause_wr(cause_wr), .low_cause_wdata(low_wd), .wdg_cause_wdata(wdg_wd),
        .low_supply_reset_cause(low_cause), .watchdog_reset_cause(wdg_cause),
        .cpu_reset(cpu_reset), .vector_fetch(vector_fetch), .vector_addr(vector_addr));
    // ****************************************
    // clock and helpers
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic step;
        @(posedge clk);
        #10;
    endtask : step
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    task automatic pulse_wdg;
        wdg = 1'b1;
        step;
        wdg = 1'b0;
    endtask : pulse_wdg
    task automatic write_cause(input logic lv, input logic wv);
        cause_wr = 1'b1;
        low_wd = lv;
        wdg_wd = wv;
        step;
        cause_wr = 1'b0;
        step;
    endtask : write_cause
    // counts pin-low cycles, then walks the fetch
    task automatic run_seq(output int n);
        int t;
        n = 0;
        t = 0;
        while (rst_pin_oe_n !== 1'b0 && t < 50) begin
            step;
            t++;
        end
        while (rst_pin_oe_n === 1'b0 && n < 6000) begin
            step;
            n++;
        end
        chk(vector_fetch, 1'b1);
        chk(vector_addr, `RSS_VEC_ADDR);
        step;
        chk(vector_fetch, 1'b1);
        chk(vector_addr, 16'hffff);
        step;
        chk(vector_fetch, 1'b0);
        step;
        chk(cpu_reset, 1'b0);
    endtask : run_seq
    // ****************************************
    // watchdog
    // ****************************************
    initial begin
        #2000000;
        error_cnt++;
        end_of_test;
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        error_cnt = 0;
        checks_done = 0;
        {rst, ext_low, low_cmp, aux_cmp, wdg, opt_long, ie_wr, ie_val} = 8'h81;
        {ack, cause_wr, low_wd, wdg_wd} = 4'h0;
        opt_en = 1'b1;
        opt_thr = 2'h1;
        repeat (5) step;
        rst = 1'b0;
        run_seq(n0);
        write_cause(1'b0, 1'b0);
        chk({low_cause, wdg_cause}, 2'h0);
        pulse_wdg;
        run_seq(ns);
        chk(ns >= `RSS_WDG_OUT_CYC + 256, 1'b1);
        chk({low_cause, wdg_cause}, 2'h1);
        opt_long = 1'b1;
        pulse_wdg;
        run_seq(nl);
        chk(nl - ns, 16'hf00);
        opt_long = 1'b0;
        pulse_wdg;
        repeat (150) step;
        pulse_wdg;
        run_seq(nr);
        chk(nr >= ns && nr <= ns + 4, 1'b1);
        low_cmp = 1'b1;
        repeat (5) step;
        repeat (40) begin
            step;
            chk(rst_pin_oe_n, 1'b0);
        end
        low_cmp = 1'b0;
        run_seq(n0);
        chk({low_cause, wdg_cause}, 2'h2);
        ext_low = 1'b1;
        repeat (5) step;
        ext_low = 1'b0;
        run_seq(n0);
        chk({low_cause, wdg_cause}, 2'h2);
        for (int i = 1; i < 4; i++) begin
            opt_thr = rss_lvl_t'(i);
            step;
            chk(thr, rss_lvl_t'(i));
        end
        aux_cmp = 1'b1;
        repeat (4) step;
        chk(aux_flag, 1'b1);
        chk(req, 1'b0);
        {ie_wr, ie_val} = 2'h3;
        step;
        ie_wr = 1'b0;
        repeat (2) step;
        chk({ie, req}, 2'h3);
        ack = 1'b1;
        step;
        ack = 1'b0;
        step;
        chk(req, 1'b0);
        aux_cmp = 1'b0;
        repeat (4) step;
        chk({aux_flag, req}, 2'h1);
        ack = 1'b1;
        step;
        ack = 1'b0;
        opt_en = 1'b0;
        low_cmp = 1'b1;
        aux_cmp = 1'b1;
        repeat (20) step;
        chk({cpu_reset, rst_pin_oe_n}, 2'h1);
        chk({aux_flag, req}, 2'h0);
        end_of_test;
    end
endmodule : testbench
`default_nettype wire
